/* File: rtl/cmft_defs.vh */
// How it works
// - each port listens to any slot on either bus
// - both buses handled by identical logic
// - outgoing dialling sends forward tones, detects backward tones
// - incoming collection sends backward tones, detects forward tones
// - automatic mode runs compelled handshake without controller steps, on ports 0 to 2 only
// - samples are A-law or mu-law PCM at the bus rate
// - sequencer decides forward or backward sending from the port's outgoing setting
// - port freed once call is cut through
// - card takes eight consecutive port addresses
// - transmit slot alone identifies the port, bus taken from the port setting
// - log of tone events kept, readable while sending
// - a poll with the log empty returns status changes since previous report
// - lamp lights when its control bit is written low
// - law switches: closed selects mu-law, open selects A-law
// - gain step disabled when switch closed, enabled when open
// - backward signal 3 means address complete, switch to group B
`ifndef CMFT_DEFS_VH
`define CMFT_DEFS_VH
`define CMFT_NPORTS       8
`define CMFT_SLOTS        32
`define CMFT_SIG_ADDR_CMP 4'h3
`define CMFT_LAMPS_RESET  3'h7
`define CMFT_LOG_DEPTH    16
`define CMFT_EV_TONE      2'h0
`define CMFT_EV_DIGIT     2'h1
`define CMFT_EV_CHANGE    2'h2
`endif

/* File: rtl/cmft_ports.v */
`timescale 1ns/1ps
`default_nettype none
`include "cmft_defs.vh"
module cmft_ports #(
  parameter LOG_DEPTH = `CMFT_LOG_DEPTH
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  cardBase,
  input  wire        pcmClk,
  input  wire        pcmSync,
  input  wire        pcmBus0,
  input  wire        pcmBus1,
  output reg         pcmTx0,
  output reg         pcmTx1,
  output reg         pcmTxEn0N,
  output reg         pcmTxEn1N,
  input  wire        cfgWr,
  input  wire [2:0]  cfgPort,
  input  wire [4:0]  cfgSlot,
  input  wire        cfgBus,
  input  wire        cfgOutgoing,
  input  wire        cfgAuto,
  input  wire [3:0]  ruleDigits,
  input  wire        cutThrough,
  input  wire [2:0]  toneValid,
  input  wire [23:0] toneCodeIn,
  output reg  [7:0]  portBusy,
  output reg  [7:0]  sendForward,
  output reg  [31:0] sendCode,
  output reg  [7:0]  groupB,
  output reg  [7:0]  rxSample,
  output reg  [2:0]  rxPort,
  output reg         rxValid,
  input  wire        poll,
  output reg         pollValid,
  output reg  [15:0] pollData,
  output reg  [7:0]  portAddr0,
  input  wire        lampWr,
  input  wire [2:0]  lampBits,
  output reg         lampRedN,
  output reg         lampYellowN,
  output reg         lampGreenN,
  input  wire        lawSwToneCard,
  input  wire        lawSwDevice,
  input  wire [2:0]  gainSw,
  output reg         toneCardMuLaw,
  output reg         deviceMuLaw,
  output reg  [2:0]  gainEnable
);
  localparam AW = 4;
  // three-stage sampling of link pins
  reg [2:0] clkS_q, syncS_q, b0S_q, b1S_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkS_q  <= 3'h0;
      syncS_q <= 3'h0;
      b0S_q   <= 3'h0;
      b1S_q   <= 3'h0;
    end else begin
      clkS_q  <= {clkS_q[1:0], pcmClk};
      syncS_q <= {syncS_q[1:0], pcmSync};
      b0S_q   <= {b0S_q[1:0], pcmBus0};
      b1S_q   <= {b1S_q[1:0], pcmBus1};
    end
  end
  reg clkLvl_q;
  wire clkAgree = (clkS_q[2] == clkS_q[1]);
  wire clkRise  = clkAgree && clkS_q[2] && !clkLvl_q;
  wire clkFall  = clkAgree && !clkS_q[2] && clkLvl_q;
  // bit and slot counters of the frame, sync resets at rise
  reg [7:0] bitCnt_q;
  reg [7:0] sh0_q, sh1_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clkLvl_q <= 1'b0;
      bitCnt_q <= 8'h00;
      sh0_q    <= 8'h00;
      sh1_q    <= 8'h00;
    end else begin
      if (clkAgree)
        clkLvl_q <= clkS_q[2];
      if (clkRise) begin
        bitCnt_q <= syncS_q[2] ? 8'h01 : bitCnt_q + 8'h01;
        sh0_q <= {sh0_q[6:0], b0S_q[2]};
        sh1_q <= {sh1_q[6:0], b1S_q[2]};
      end
    end
  end
  wire [7:0] bitNow = syncS_q[2] ? 8'h00 : bitCnt_q;
  wire [4:0] slotDone = bitNow[7:3] - 5'h01;
  wire [4:0] slotNext = bitNow[7:3] + 5'h01;  // wraps from slot 31 to slot 0
  // per port configuration table
  reg [4:0] slot_q [0:7];
  reg [7:0] busSel_q, outgo_q, auto_q;
  reg [3:0] digCnt_q [0:7];
  // port capture: one octet per port per frame, last slot closes at frame start
  integer i;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxValid <= 1'b0;
      rxPort  <= 3'h0;
      rxSample <= 8'h00;
    end else begin
      rxValid <= 1'b0;
      if (clkRise && bitNow[2:0] == 3'h0) begin
        for (i = 0; i < 8; i = i + 1) begin
          if (portBusy[i] && slot_q[i] == slotDone) begin
            rxValid  <= 1'b1;
            rxPort   <= i[2:0];
            rxSample <= busSel_q[i] ? sh1_q : sh0_q;
          end
        end
      end
    end
  end
  // transmit: load on last bit of previous slot so the octet fills its own slot
  reg [7:0] txSh_q;
  reg       txOn_q, txBus_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txSh_q <= 8'h00;
      txOn_q <= 1'b0;
      txBus_q <= 1'b0;
      pcmTx0 <= 1'b0;
      pcmTx1 <= 1'b0;
      pcmTxEn0N <= 1'b1;
      pcmTxEn1N <= 1'b1;
    end else begin
      if (clkRise && bitNow[2:0] == 3'h7) begin
        txOn_q <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
          // transmit slot alone identifies port, bus taken from it
          if (portBusy[i] && slot_q[i] == slotNext) begin
            txOn_q  <= 1'b1;
            txBus_q <= busSel_q[i];
            txSh_q  <= {sendForward[i], 3'h0, sendCode[4*i +: 4]};
          end
        end
      end else if (clkRise) begin
        txSh_q <= {txSh_q[6:0], 1'b0};
      end
      if (clkFall) begin
        pcmTx0 <= txSh_q[7];
        pcmTx1 <= txSh_q[7];
        pcmTxEn0N <= !(txOn_q && !txBus_q);
        pcmTxEn1N <= !(txOn_q && txBus_q);
      end
    end
  end
  // event log
  reg [15:0] log_q [0:LOG_DEPTH-1];
  reg [AW-1:0] wp_q, rp_q;
  reg [AW:0] cnt_q;
  reg [7:0] chg_q;
  reg       evW;
  reg [15:0] evD;
  integer k;
  always @* begin
    evW = 1'b0;
    evD = 16'h0000;
    for (k = 0; k < 3; k = k + 1) begin
      if (toneValid[k] && !evW) begin
        evW = 1'b1;
        evD = {`CMFT_EV_TONE, 3'h0, k[2:0], 4'h0, toneCodeIn[8*k +: 4]};
      end
    end
  end
  // port state: sequencer, handshake, release
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portBusy <= 8'h00;
      busSel_q <= 8'h00;
      outgo_q <= 8'h00;
      auto_q <= 8'h00;
      sendForward <= 8'h00;
      sendCode <= 32'h0000_0000;
      groupB <= 8'h00;
      chg_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        slot_q[i] <= 5'h00;
        digCnt_q[i] <= 4'h0;
      end
    end else begin
      if (cfgWr) begin
        slot_q[cfgPort] <= cfgSlot;
        busSel_q[cfgPort] <= cfgBus;
        outgo_q[cfgPort] <= cfgOutgoing;
        auto_q[cfgPort] <= cfgAuto;
        portBusy[cfgPort] <= 1'b1;
        groupB[cfgPort] <= 1'b0;
        digCnt_q[cfgPort] <= 4'h0;
        sendForward[cfgPort] <= cfgOutgoing;
        sendCode[4*cfgPort +: 4] <= 4'h0;
      end
      if (cutThrough)
        portBusy[cfgPort] <= 1'b0;
      for (i = 0; i < 3; i = i + 1) begin
        if (toneValid[i] && portBusy[i] && auto_q[i]) begin
          if (outgo_q[i]) begin
            if (toneCodeIn[8*i +: 4] == `CMFT_SIG_ADDR_CMP)
              groupB[i] <= 1'b1;
            else if (digCnt_q[i] < ruleDigits) begin
              digCnt_q[i] <= digCnt_q[i] + 4'h1;
              sendCode[4*i +: 4] <= digCnt_q[i] + 4'h1;
            end
          end else begin
            sendCode[4*i +: 4] <= (digCnt_q[i] + 4'h1 >= ruleDigits) ? `CMFT_SIG_ADDR_CMP : 4'h1;
            digCnt_q[i] <= digCnt_q[i] + 4'h1;
          end
        end
      end
      // change flags, set wins over clear
      chg_q <= ((poll && cnt_q == 0) ? 8'h00 : chg_q) | {5'h00, toneValid};
    end
  end
  // ordered log, events arriving while full are dropped
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      pollValid <= 1'b0;
      pollData <= 16'h0000;
    end else begin
      pollValid <= 1'b0;
      if (evW && cnt_q != LOG_DEPTH) begin
        log_q[wp_q] <= evD;
        wp_q <= wp_q + 1'b1;
      end
      if (poll) begin
        pollValid <= 1'b1;
        if (cnt_q != 0) begin
          pollData <= log_q[rp_q];
          rp_q <= rp_q + 1'b1;
        end else
          pollData <= {`CMFT_EV_CHANGE, 6'h00, chg_q};
      end
      cnt_q <= cnt_q + ((evW && cnt_q != LOG_DEPTH) ? 1'b1 : 1'b0) - ((poll && cnt_q != 0) ? 1'b1 : 1'b0);
    end
  end
  // lamps, switches, card address
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {lampRedN, lampYellowN, lampGreenN} <= `CMFT_LAMPS_RESET;
      toneCardMuLaw <= 1'b0;
      deviceMuLaw <= 1'b0;
      gainEnable <= 3'h0;
      portAddr0 <= 8'h00;
    end else begin
      if (lampWr)
        {lampRedN, lampYellowN, lampGreenN} <= lampBits;
      toneCardMuLaw <= lawSwToneCard;
      deviceMuLaw <= lawSwDevice;
      gainEnable <= ~gainSw;
      portAddr0 <= {cardBase[7:3], 3'h0};
    end
  end
endmodule
`default_nettype wire

/* File: test/cmft_ports_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cmft_ports_sva (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] cardBase,
  input wire logic       cfgWr,
  input wire logic [2:0] cfgPort,
  input wire logic       cfgOutgoing,
  input wire logic       cutThrough,
  input wire logic [7:0] portBusy,
  input wire logic [7:0] sendForward,
  input wire logic       poll,
  input wire logic       pollValid,
  input wire logic [7:0] portAddr0,
  input wire logic       lampWr,
  input wire logic [2:0] lampBits,
  input wire logic       lampRedN,
  input wire logic       lampYellowN,
  input wire logic       lampGreenN,
  input wire logic       lawSwToneCard,
  input wire logic       lawSwDevice,
  input wire logic [2:0] gainSw,
  input wire logic       toneCardMuLaw,
  input wire logic       deviceMuLaw,
  input wire logic [2:0] gainEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // poll answer: one cycle later, for one cycle
  sequence s_answer;
    ##1 pollValid ##1 !pollValid;
  endsequence
  a_cfg_busy: assert property (cfgWr |=> portBusy[$past(cfgPort)])
    else $error("configured port not busy");
  a_cfg_dir: assert property (cfgWr |=> sendForward[$past(cfgPort)] == $past(cfgOutgoing))
    else $error("send direction wrong");
  a_cut_free: assert property (cutThrough && !cfgWr |=> !portBusy[$past(cfgPort)])
    else $error("port not freed");
  a_poll_answer: assert property (poll |-> s_answer)
    else $error("poll answer wrong");
  a_base_addr: assert property (1 |=> portAddr0 == {$past(cardBase[7:3]), 3'h0})
    else $error("port base wrong");
  a_lamp_write: assert property (lampWr |=> {lampRedN, lampYellowN, lampGreenN} == $past(lampBits))
    else $error("lamp bits wrong");
  a_law_select: assert property (1 |=> {toneCardMuLaw, deviceMuLaw} == $past({lawSwToneCard, lawSwDevice}))
    else $error("law select wrong");
  a_gain_select: assert property (1 |=> gainEnable == ~$past(gainSw))
    else $error("gain enable wrong");
endmodule
bind cmft_ports cmft_ports_sva i_sva (.clk_sys, .rst_n, .cardBase, .cfgWr, .cfgPort, .cfgOutgoing, .cutThrough,
  .portBusy, .sendForward, .poll, .pollValid, .portAddr0, .lampWr, .lampBits, .lampRedN, .lampYellowN,
  .lampGreenN, .lawSwToneCard, .lawSwDevice, .gainSw, .toneCardMuLaw, .deviceMuLaw, .gainEnable);
`default_nettype wire

/* File: test/cmft_pcm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmft_pcm_model (
  output var logic pcmClk,
  output var logic pcmSync,
  output var logic pcmBus0,
  output var logic pcmBus1
);
  logic [7:0] bitN;
  logic [7:0] oct0;
  logic [7:0] oct1;
  // backplane bit clock runs free
  initial begin
    {pcmClk, pcmSync, pcmBus0, pcmBus1, bitN} = '0;
  end
  always #400 pcmClk = ~pcmClk;
  // octets msb first, change on fall
  always @(negedge pcmClk) begin
    oct0 = {3'h0, bitN[7:3]} ^ 8'h5A;
    oct1 = {3'h4, bitN[7:3]} ^ 8'h5A;
    pcmSync <= bitN == 8'h00;
    pcmBus0 <= oct0[3'h7 - bitN[2:0]];
    pcmBus1 <= oct1[3'h7 - bitN[2:0]];
    bitN <= bitN + 8'h01;
  end
endmodule
`default_nettype wire

/* File: test/cmft_ports_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cmft_ports_test;
  logic        clk_sys, rst_n, pcmClk, pcmSync, pcmBus0, pcmBus1, pcmTxEn0N, pcmTxEn1N, cfgWr, cfgBus;
  logic        cfgOutgoing, cfgAuto, cutThrough, rxValid, poll, pollValid, lampWr, lampRedN, lampYellowN;
  logic        lampGreenN, lawSwToneCard, lawSwDevice, toneCardMuLaw, deviceMuLaw, pcmTx0, pcmTx1;
  logic [2:0]  cfgPort, toneValid, rxPort, lampBits, gainSw, gainEnable, rp;
  logic [3:0]  ruleDigits;
  logic [4:0]  cfgSlot, rs;
  logic [7:0]  cardBase, portBusy, sendForward, groupB, rxSample, portAddr0;
  logic [15:0] pollData;
  logic [23:0] toneCodeIn;
  logic [31:0] sendCode;
  integer      failures = 0, n_tests = 0, seed = 53162, i, k;
  cmft_pcm_model i_pcm (.pcmClk, .pcmSync, .pcmBus0, .pcmBus1);
  cmft_ports i_dut (.clk_sys, .rst_n, .cardBase, .pcmClk, .pcmSync, .pcmBus0, .pcmBus1, .pcmTx0, .pcmTx1,
    .pcmTxEn0N, .pcmTxEn1N, .cfgWr, .cfgPort, .cfgSlot, .cfgBus, .cfgOutgoing, .cfgAuto, .ruleDigits, .cutThrough,
    .toneValid, .toneCodeIn, .portBusy, .sendForward, .sendCode, .groupB, .rxSample, .rxPort, .rxValid, .poll,
    .pollValid, .pollData, .portAddr0, .lampWr, .lampBits, .lampRedN, .lampYellowN, .lampGreenN, .lawSwToneCard,
    .lawSwDevice, .gainSw, .toneCardMuLaw, .deviceMuLaw, .gainEnable);
  always #50 clk_sys = ~clk_sys;
  // expected octet on a slot of a bus
  function automatic logic [7:0] pat(input logic [4:0] s, input logic b);
    return {b, 2'h0, s} ^ 8'h5A;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask
  task automatic ask;
    pulse(poll);
    tick;
  endtask
  task automatic cfg(input logic [2:0] p, input logic [4:0] s, input logic b, input logic o);
    cfgPort = p;
    cfgSlot = s;
    cfgBus = b;
    cfgOutgoing = o;
    cfgAuto = 1'b1;
    pulse(cfgWr);
    chk({portBusy[p], sendForward[p]}, {1'b1, o});
  endtask
  task automatic tally_and_finish;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog over the whole run
  initial begin
    #5_000_000;
    failures++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    {clk_sys, rst_n, cfgWr, cfgBus, cfgOutgoing, cfgAuto, cutThrough, poll, lampWr} = '0;
    {lawSwToneCard, lawSwDevice, cfgPort, cfgSlot, toneValid, toneCodeIn, lampBits, gainSw} = '0;
    ruleDigits = 4'h4;
    cardBase = $random(seed);
    repeat (3) tick;
    rst_n = 1'b1;
    tick;
    chk({lampRedN, lampYellowN, lampGreenN, pcmTxEn0N, pcmTxEn1N, portBusy}, {5'h1F, 8'h00});
    chk(portAddr0, {cardBase[7:3], 3'h0});
    for (k = 0; k < 8; k++) begin
      {lawSwToneCard, lawSwDevice, gainSw} = $random(seed);
      lampBits = k[2:0];
      pulse(lampWr);
      chk({toneCardMuLaw, deviceMuLaw, gainEnable}, {lawSwToneCard, lawSwDevice, ~gainSw});
      chk({lampRedN, lampYellowN, lampGreenN}, lampBits);
    end
    lawSwDevice = 1'b0; // device switch left at A-law
    for (k = 0; k < 4; k++) begin
      rp = $random(seed);
      rs = $random(seed);
      cfg(rp, rs, k[0], k[1]);
      for (i = 0; i < 3000 && !(rxValid === 1'b1 && rxPort === rp); i++) tick;
      chk({rxValid, rxPort, rxSample}, {1'b1, rp, pat(rs, k[0])});
      for (i = 0; i < 3000 && (k[0] ? pcmTxEn1N : pcmTxEn0N) !== 1'b0; i++) tick;
      chk({pcmTxEn1N, pcmTxEn0N, k[0] ? pcmTx1 : pcmTx0}, {~k[0], k[0], k[1]});
      pulse(cutThrough);
      chk(portBusy[rp], 1'b0);
    end
    for (i = 0; i < 40 && pollData[15:14] !== 2'h2; i++) ask;
    cfg(3'h0, 5'h01, 1'b0, 1'b1);
    cfg(3'h1, 5'h02, 1'b1, 1'b0);
    toneCodeIn = 24'h00_0503;
    toneValid = 3'h1;
    tick;
    toneValid = 3'h2;
    tick;
    toneValid = 3'h0;
    for (i = 0; i < 20 && groupB[0] !== 1'b1; i++) tick;
    chk({groupB[0], sendCode[7:4]}, {1'b1, 4'h1});
    ask;
    chk(pollData, 16'h0003);
    ask;
    chk(pollData, 16'h0105);
    ask;
    chk(pollData[15:14], 2'h2);
    ask;
    chk(pollData, 16'h8000);
    tally_and_finish;
  end
endmodule
`default_nettype wire
